// file: common/bf_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the
  breaker failure scheme. Assumes inclusion by bare name.
*/
`ifndef BF_CONSTS_SVH
`define BF_CONSTS_SVH
`define BF_CLK_PERIOD_NS 20
`define BF_TICK_PERIOD_NS 1000000
`define BF_A_CTRL   8'h00
`define BF_A_SEL0   8'h04
`define BF_A_SEL1   8'h08
`define BF_A_DEARLY 8'h0c
`define BF_A_DMAIN  8'h10
`define BF_A_DSLOW  8'h14
`define BF_A_DLOW   8'h18
`define BF_A_DHOLD  8'h1c
`define BF_A_TGATE  8'h20
`define BF_A_THIGH  8'h24
`define BF_A_TLOW   8'h28
`define BF_A_STAT   8'h2c
`define BF_C_FUNC  0
`define BF_C_MODE  1
`define BF_C_IGATE 2
`define BF_C_LGATE 3
`define BF_C_EARLY 4
`define BF_C_MAIN  5
`define BF_C_SLOW  6
`define BF_S_3P  0
`define BF_S_PA  4
`define BF_S_BLK 16
`define BF_S_OOS 20
`define BF_S_NA  0
`define BF_S_EB  4
`define BF_S_EC  8
`define BF_S_NC  12
`define BF_RST_CTRL 7'h7c
`define BF_RST_THR  32'h041a_041a
`endif

// file: common/bf_pkg.sv
/*
  Types of the breaker failure scheme.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package bf_pkg;
  typedef enum logic {mode_three = 1'b0, mode_single = 1'b1} pole_mode_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
  } timer_state_t;
endpackage
`default_nettype wire

// file: common/bf_timer_if.sv
/*
  Run, delay and expiry of one path timer.
  Assumes the owner drives run and delay on hclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface bf_timer_if;
  logic        run;
  logic [15:0] delay;
  logic        done;
  modport owner (output run, output delay, input done);
  modport timer (input run, input delay, output done);
endinterface
`default_nettype wire

// file: hdl/bf_sync.sv
/*
  Two-flop synchroniser for pin inputs.
  Assumes hclk and a clock enable shared with its user.
*/
`timescale 1ns/1ns
`default_nettype none
module bf_sync
#(
  parameter int W = 8
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t s;
  sync_t next_s;
  always_comb
  begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end
  assign q = s.s2;
endmodule
`default_nettype wire

// file: hdl/bf_timer.sv
/*
  Millisecond pickup timer of one path.
  Assumes a one-cycle tick each millisecond and a synchronous clear.
*/
`timescale 1ns/1ns
`default_nettype none
module bf_timer
  import bf_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic clear,
  bf_timer_if.timer tp
);
  timer_state_t s;
  timer_state_t next_s;
  always_comb
  begin
    next_s = s;
    if (clear || !tp.run)
    begin
      next_s.cnt = 16'h0000;
      next_s.done = 1'b0;
    end
    else if (s.cnt >= tp.delay)
      next_s.done = 1'b1;
    else if (tick)
      next_s.cnt = s.cnt + 16'h0001;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else if (ce)
      s <= next_s;
  end
  assign tp.done = s.done;
  AST_TMR_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !tp.run) |=> !tp.done && s.cnt == 16'h0000)
    else $error("timer kept state after run dropped");
  AST_TMR_EXPIRY: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tp.done) |-> $past(s.cnt >= tp.delay && tp.run))
    else $error("timer expired before its delay");
endmodule
`default_nettype wire

// file: hdl/bf_scheme.sv
/*
  Breaker failure scheme with early, main and slow paths, AHB-Lite
  settings, re-trip, zone trip seal-in and indications.
  Assumes current magnitudes arrive on hclk and operands on pins.
*/
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "bf_consts.svh"
module bf_scheme
  import bf_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BF_TICK_PERIOD_NS / `BF_CLK_PERIOD_NS
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic [14:0]      operand_in,
  input  wire logic [2:0][15:0] phase_mag,
  input  wire logic [15:0]      neutral_mag,
  output logic [2:0]            retrip,
  output logic [2:0]            early_fail,
  output logic [2:0]            main_fail,
  output logic [2:0]            slow_fail,
  output logic                  zone_trip_output,
  output logic                  reclose_cancel,
  output logic                  target_flag,
  output logic                  trip_led,
  output logic [2:0]            phase_led
);
  typedef struct packed {
    logic [6:0]  ctrl;
    logic [23:0] sel0;
    logic [15:0] sel1;
    logic [15:0] d_early;
    logic [15:0] d_main;
    logic [15:0] d_slow;
    logic [15:0] d_low;
    logic [15:0] d_hold;
    logic [31:0] thr_gate;
    logic [31:0] thr_high;
    logic [31:0] thr_low;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [2:0]  latched;
    logic [2:0]  retrip;
    logic [2:0]  early_fail;
    logic [2:0]  main_fail;
    logic [2:0]  slow_fail;
    logic        zone;
    logic [15:0] hold_cnt;
    logic        target;
    logic [2:0]  phase_led;
  } state_t;

  state_t s;
  state_t next_s;

  logic [14:0]     op_sync;
  logic [15:0]     op;
  logic            single;
  logic            kill;
  logic            oos;
  logic            any_fail;
  logic            gate3;
  logic            high3;
  logic            low3;
  logic [2:0]      pg_hit;
  logic [2:0]      ph_hit;
  logic [2:0]      pl_hit;
  logic [2:0]      start;
  logic [2:0]      gate;
  logic [2:0]      high;
  logic [2:0]      low;
  logic [2:0]      aux_e;
  logic [2:0]      aux_s;
  logic [2:0]      accepted;
  logic [2:0]      active;
  logic [2:0]      detect;
  logic [2:0]      latch_n;
  logic [2:0]      early_n;
  logic [2:0]      main_n;
  logic [2:0]      slow_n;
  logic [2:0][4:0] tdone;

  bf_sync #(.W(15)) u_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (operand_in),
    .q       (op_sync)
  );

  // operand index 0 is the constant off operand
  assign op     = {op_sync, 1'b0};
  assign single = (pole_mode_t'(s.ctrl[`BF_C_MODE]) == mode_single);
  assign kill   = !s.ctrl[`BF_C_FUNC] || op[s.sel0[`BF_S_BLK +: 4]];
  assign oos    = op[s.sel0[`BF_S_OOS +: 4]];
  // neutral counts only in three-pole mode
  assign gate3  = (|pg_hit) || (neutral_mag > s.thr_gate[31:16]);
  assign high3  = (|ph_hit) || (neutral_mag > s.thr_high[31:16]);
  assign low3   = (|pl_hit) || (neutral_mag > s.thr_low[31:16]);

  bf_timer_if tif [15] ();

  genvar p;
  genvar k;
  generate
    for (p = 0; p < 3; p++)
    begin : g_pole
      localparam int AE = (p == 0) ? `BF_S_NA : (p == 1) ? `BF_S_EB : `BF_S_EC;
      localparam int AS = (p == 0) ? `BF_S_NA : (p == 1) ? `BF_S_EB : `BF_S_NC;
      localparam int SP = `BF_S_PA + 4 * p;
      assign pg_hit[p] = phase_mag[p] > s.thr_gate[15:0];
      assign ph_hit[p] = phase_mag[p] > s.thr_high[15:0];
      assign pl_hit[p] = phase_mag[p] > s.thr_low[15:0];
      if (p == 0)
      begin : g_lead
        assign start[p] = single ? op[s.sel0[SP +: 4]] : op[s.sel0[`BF_S_3P +: 4]];
        assign gate[p]  = single ? pg_hit[p] : gate3;
        assign high[p]  = single ? ph_hit[p] : high3;
        assign low[p]   = single ? pl_hit[p] : low3;
      end
      else
      begin : g_side
        assign start[p] = single && op[s.sel0[SP +: 4]];
        assign gate[p]  = pg_hit[p];
        assign high[p]  = ph_hit[p];
        assign low[p]   = pl_hit[p];
      end
      assign aux_e[p]    = op[s.sel1[AE +: 4]];
      assign aux_s[p]    = op[s.sel1[AS +: 4]];
      assign accepted[p] = !kill && start[p] && (!s.ctrl[`BF_C_IGATE] || gate[p]);
      assign active[p]   = accepted[p] || (!kill && s.latched[p]);
      assign latch_n[p]  = active[p] && (!s.ctrl[`BF_C_LGATE] || gate[p]);
      assign tif[p*5+0].run   = active[p] && s.ctrl[`BF_C_EARLY];
      assign tif[p*5+0].delay = s.d_early;
      assign tif[p*5+1].run   = active[p] && s.ctrl[`BF_C_MAIN];
      assign tif[p*5+1].delay = s.d_main;
      assign tif[p*5+2].run   = active[p] && s.ctrl[`BF_C_SLOW] && aux_s[p] && !oos;
      assign tif[p*5+2].delay = s.d_slow;
      // low stage timer starts once the early or main timer has expired
      assign tif[p*5+3].run   = active[p] && (tdone[p][0] || tdone[p][1]);
      assign tif[p*5+3].delay = s.d_low;
      assign tif[p*5+4].run   = 1'b0;
      assign tif[p*5+4].delay = 16'h0000;
      assign detect[p] = ((tdone[p][0] || tdone[p][1]) && high[p])
                       || (tdone[p][3] && low[p]);
      assign early_n[p] = !kill && tdone[p][0] && aux_e[p] && detect[p];
      assign main_n[p]  = !kill && tdone[p][1] && detect[p];
      assign slow_n[p]  = !kill && tdone[p][2];
      for (k = 0; k < 5; k++)
      begin : g_tmr
        if (k < 4)
        begin : g_used
          bf_timer u_tmr
          (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ce      (ce),
            .tick    (s.tick),
            .clear   (kill),
            .tp      (tif[p*5+k])
          );
          assign tdone[p][k] = tif[p*5+k].done;
        end
        else
        begin : g_spare
          assign tif[p*5+k].done = 1'b0;
          assign tdone[p][k] = tif[p*5+k].done;
        end
      end
    end
  endgenerate

  assign any_fail = |(s.early_fail | s.main_fail | s.slow_fail);

  function automatic logic [31:0] reg_read(input state_t x, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `BF_A_CTRL:   r = {25'h0, x.ctrl};
      `BF_A_SEL0:   r = {8'h00, x.sel0};
      `BF_A_SEL1:   r = {16'h0000, x.sel1};
      `BF_A_DEARLY: r = {16'h0000, x.d_early};
      `BF_A_DMAIN:  r = {16'h0000, x.d_main};
      `BF_A_DSLOW:  r = {16'h0000, x.d_slow};
      `BF_A_DLOW:   r = {16'h0000, x.d_low};
      `BF_A_DHOLD:  r = {16'h0000, x.d_hold};
      `BF_A_TGATE:  r = x.thr_gate;
      `BF_A_THIGH:  r = x.thr_high;
      `BF_A_TLOW:   r = x.thr_low;
      `BF_A_STAT:   r = {15'h0, x.retrip, x.slow_fail, x.main_fail,
                         x.early_fail, x.zone, x.phase_led, x.target};
      default:      r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb
  begin
    next_s = s;
    // millisecond tick
    if (s.tick_cnt >= 16'(TICK_CYCLES - 1))
    begin
      next_s.tick_cnt = 16'h0000;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.tick_cnt = s.tick_cnt + 16'h0001;
      next_s.tick = 1'b0;
    end
    // data phase of a write
    if (s.wr_pend)
    begin
      case (s.wr_addr)
        `BF_A_CTRL:   next_s.ctrl = hwdata[6:0];
        `BF_A_SEL0:   next_s.sel0 = hwdata[23:0];
        `BF_A_SEL1:   next_s.sel1 = hwdata[15:0];
        `BF_A_DEARLY: next_s.d_early = hwdata[15:0];
        `BF_A_DMAIN:  next_s.d_main = hwdata[15:0];
        `BF_A_DSLOW:  next_s.d_slow = hwdata[15:0];
        `BF_A_DLOW:   next_s.d_low = hwdata[15:0];
        `BF_A_DHOLD:  next_s.d_hold = hwdata[15:0];
        `BF_A_TGATE:  next_s.thr_gate = hwdata;
        `BF_A_THIGH:  next_s.thr_high = hwdata;
        `BF_A_TLOW:   next_s.thr_low = hwdata;
        `BF_A_STAT:
        begin
          next_s.target = s.target && !hwdata[0];
          next_s.phase_led = s.phase_led & ~hwdata[3:1];
        end
        default:      next_s.ctrl = s.ctrl;
      endcase
    end
    // scheme state; sets follow the clears so a set wins
    next_s.latched = latch_n;
    next_s.retrip = active;
    next_s.early_fail = early_n;
    next_s.main_fail = main_n;
    next_s.slow_fail = slow_n;
    if (kill)
    begin
      next_s.zone = 1'b0;
      next_s.hold_cnt = 16'h0000;
      next_s.target = 1'b0;
      next_s.phase_led = 3'h0;
    end
    else
    begin
      if (any_fail)
      begin
        next_s.zone = 1'b1;
        next_s.hold_cnt = 16'h0000;
        next_s.target = 1'b1;
      end
      else if (s.zone)
      begin
        if (s.hold_cnt >= s.d_hold)
          next_s.zone = 1'b0;
        else if (s.tick)
          next_s.hold_cnt = s.hold_cnt + 16'h0001;
      end
      if (single)
        next_s.phase_led = next_s.phase_led
                         | s.early_fail | s.main_fail | s.slow_fail;
    end
    // address phase; reads see a write landing in the same cycle
    next_s.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      next_s.wr_pend = hwrite;
      next_s.wr_addr = haddr[7:0];
      if (!hwrite)
        next_s.hrdata = reg_read(next_s, haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.ctrl <= `BF_RST_CTRL;
      s.thr_gate <= `BF_RST_THR;
      s.thr_high <= `BF_RST_THR;
      s.thr_low <= `BF_RST_THR;
      s.hreadyout <= 1'b1;
    end
    else if (ce)
      s <= next_s;
  end

  assign hreadyout        = s.hreadyout;
  assign hrdata           = s.hrdata;
  assign hresp            = s.wr_pend && 1'b0;
  assign retrip           = s.retrip;
  assign early_fail       = s.early_fail;
  assign main_fail        = s.main_fail;
  assign slow_fail        = s.slow_fail;
  assign zone_trip_output = s.zone;
  assign reclose_cancel   = s.zone;
  assign target_flag      = s.target;
  assign trip_led         = s.target;
  assign phase_led        = s.phase_led;

  AST_KILL_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && kill) |=> (retrip == 3'h0 && !zone_trip_output && !target_flag))
    else $error("outputs active while scheme disabled or blocked");
  AST_RETRIP_NOW: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && accepted[0]) |=> retrip[0])
    else $error("accepted initiate gave no re-trip");
  AST_INIT_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !kill && start[0] && s.ctrl[`BF_C_IGATE] && !gate[0] && !s.latched[0])
    |=> !retrip[0])
    else $error("initiate accepted below gate threshold");
  AST_SLOW_BLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(slow_fail[0]) |-> $past(!oos && aux_s[0] && s.ctrl[`BF_C_SLOW]))
    else $error("slow path failed while out of service or disabled");
  AST_MAIN_EN: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(main_fail[0]) |-> $past(s.ctrl[`BF_C_MAIN]))
    else $error("disabled main path declared failure");
  AST_EARLY_AUX: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(early_fail[0]) |-> $past(aux_e[0] && detect[0]))
    else $error("early failure without aux contact and current");
  AST_ZONE_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && any_fail && !kill) |=> zone_trip_output && reclose_cancel)
    else $error("failure without zone trip");
  AST_ZONE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(zone_trip_output) |-> $past(kill || (!any_fail && s.hold_cnt >= s.d_hold)))
    else $error("zone trip dropped before hold time");
  AST_SIDE_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !single && !s.latched[2]) |=> !retrip[2])
    else $error("pole C active in three-pole mode");
endmodule
`default_nettype wire

// file: tb/bf_breaker_model.sv
/*
  Behavioural three-pole breaker: aux contacts and fault current.
  Assumes per-pole trip commands on hclk from the scheme under test.
*/
`timescale 1ns/1ns
`default_nettype none
module bf_breaker_model
#(
  parameter int OPEN_CYCLES = 30
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [2:0]       trip,
  input  wire logic [2:0]       stuck_mech,
  input  wire logic [2:0]       stuck_arc,
  input  wire logic             fault_on,
  input  wire logic [15:0]      fault_level,
  output logic      [2:0]       aux_closed,
  output logic      [2:0][15:0] current
);
  int         cnt [3];
  logic [2:0] cleared;

  // a pole opens once its trip has been high for the opening time in total; the count only clears on reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int p = 0; p < 3; p++)
        cnt[p] <= 0;
      aux_closed <= 3'h7;
      cleared    <= 3'h0;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
      begin
        if (trip[p] && cnt[p] < OPEN_CYCLES)
          cnt[p] <= cnt[p] + 1;
        if (cnt[p] == OPEN_CYCLES)
        begin
          aux_closed[p] <= stuck_mech[p];
          cleared[p]    <= ~stuck_mech[p] & ~stuck_arc[p];
        end
      end
    end
  end

  // stuck arc keeps current flowing with contacts apart
  always_comb
  begin
    for (int p = 0; p < 3; p++)
      current[p] = (fault_on && !cleared[p]) ? fault_level : 16'h0;
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
  Self-checking bench of the breaker failure scheme.
  Assumes the breaker model on the trip and aux contact side.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bf_consts.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import bf_pkg::*;
  localparam int T = 10;
  logic             hclk, hresetn, ce, hsel, hwrite, single, fault;
  logic             init3, blk, oos, pa, pb, pc, hreadyout, hresp;
  logic             zone, rc, tgt, tled;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [2:0]       retrip, ef, mf, sf, pled, aux, mech, arc;
  logic [15:0]      nmag, lvl;
  logic [2:0][15:0] pmag;
  logic [14:0]      opnd;
  logic [18:0]      obs;
  int               mismatches, n_checks, cyc;

  assign opnd = {5'h0, aux[2], aux[2], aux[1], pc, pb, pa, aux[0], oos, blk, init3};
  assign obs = {pled, tled, tgt, rc, zone, sf, mf, ef, retrip};

  bf_scheme #(.TICK_CYCLES(T)) dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .operand_in(opnd), .phase_mag(pmag), .neutral_mag(nmag), .retrip(retrip),
    .early_fail(ef), .main_fail(mf), .slow_fail(sf), .zone_trip_output(zone),
    .reclose_cancel(rc), .target_flag(tgt), .trip_led(tled), .phase_led(pled));

  bf_breaker_model #(.OPEN_CYCLES(3 * T)) brk (.hclk(hclk), .hresetn(hresetn),
    .trip(single ? retrip : {3{retrip[0]}}), .stuck_mech(mech), .stuck_arc(arc),
    .fault_on(fault), .fault_level(lvl), .aux_closed(aux), .current(pmag));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic wt(input int b, input logic v, input int lim, output int n);
    n = 0;
    @(negedge hclk);
    while (obs[b] !== v && n < lim)
    begin
      @(negedge hclk);
      n++;
    end
  endtask

  function automatic logic inwin(input int n, input int d);
    return n >= (d - 1) * T - 2 && n <= d * T + 8;
  endfunction

  task automatic start(input logic [31:0] ctrl, input logic [15:0] l);
    @(posedge hclk);
    hresetn <= 1'b0;
    {init3, blk, oos, pa, pb, pc, fault, mech, arc, nmag} <= '0;
    single <= ctrl[1];
    lvl    <= l;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    wr(`BF_A_SEL0, 32'h0032_7651);
    wr(`BF_A_SEL1, 32'h0000_a984);
    wr(`BF_A_DEARLY, 32'h2);
    wr(`BF_A_DMAIN, 32'h6);
    wr(`BF_A_DSLOW, 32'hc);
    wr(`BF_A_DLOW, 32'h3);
    wr(`BF_A_DHOLD, 32'h3);
    wr(`BF_A_TGATE, 32'h0100_0100);
    wr(`BF_A_THIGH, 32'h0200_0200);
    wr(`BF_A_TLOW, 32'h0100_0100);
    wr(`BF_A_CTRL, ctrl);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    ahb(1'b0, `BF_A_CTRL, 32'h0, r);
    `CHK(r, `BF_RST_CTRL);
    ahb(1'b0, `BF_A_TGATE, 32'h0, r);
    `CHK(r, `BF_RST_THR);
    wr(`BF_A_DMAIN, 32'h0000_1234);
    ahb(1'b0, `BF_A_DMAIN, 32'h0, r);
    `CHK(r, 32'h0000_1234);
    wr(8'h30, 32'hffff_ffff);
    ahb(1'b0, 8'h30, 32'h0, r);
    `CHK(r, 32'h0);
    `CHK(hresp, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_main();
    int n;
    start(32'h6d, 16'h0300);
    @(posedge hclk);
    arc   <= 3'h7;
    fault <= 1'b1;
    init3 <= 1'b1;
    wt(0, 1'b1, 10, n);
    `CHK(n <= 4, 1'b1);
    wt(6, 1'b1, 80, n);
    `CHK(inwin(n, 6), 1'b1);
    `CHK(ef, 3'h0);
    wt(12, 1'b1, 3, n);
    `CHK(obs[15:12], 4'hf);
    `CHK(pled, 3'h0);
    @(posedge hclk);
    fault <= 1'b0;
    init3 <= 1'b0;
    wt(12, 1'b0, 50, n);
    `CHK(n >= 2 * T && n <= 3 * T + 8, 1'b1);
    `CHK(tgt, 1'b1);
    $display("test main path done");
  endtask

  task automatic t_gate();
    int n;
    start(32'h6d, 16'h0080);
    @(posedge hclk);
    fault <= 1'b1;
    init3 <= 1'b1;
    repeat (8) @(negedge hclk);
    `CHK(retrip, 3'h0);
    @(posedge hclk);
    nmag <= 16'h0200;
    wt(0, 1'b1, 10, n);
    `CHK(retrip[0], 1'b1);
    @(posedge hclk);
    init3 <= 1'b0;
    repeat (6) @(negedge hclk);
    `CHK(retrip[0], 1'b1);
    @(posedge hclk);
    nmag <= 16'h0;
    repeat (4) @(negedge hclk);
    `CHK(retrip[0], 1'b0);
    start(32'h69, 16'h0);
    @(posedge hclk);
    init3 <= 1'b1;
    wt(0, 1'b1, 10, n);
    `CHK(retrip[0], 1'b1);
    $display("test current gate done");
  endtask

  task automatic t_slow();
    int n;
    start(32'h41, 16'h0);
    @(posedge hclk);
    mech  <= 3'h7;
    init3 <= 1'b1;
    wt(9, 1'b1, 130, n);
    `CHK(inwin(n, 12), 1'b1);
    `CHK(mf, 3'h0);
    start(32'h41, 16'h0);
    @(posedge hclk);
    mech  <= 3'h7;
    oos   <= 1'b1;
    init3 <= 1'b1;
    repeat (140) @(negedge hclk);
    `CHK(sf, 3'h0);
    $display("test slow path done");
  endtask

  task automatic t_early();
    int n;
    start(32'h1d, 16'h0300);
    @(posedge hclk);
    mech  <= 3'h7;
    fault <= 1'b1;
    init3 <= 1'b1;
    wt(3, 1'b1, 40, n);
    `CHK(inwin(n, 2), 1'b1);
    repeat (60) @(negedge hclk);
    `CHK(mf, 3'h0);
    start(32'h2d, 16'h0180);
    @(posedge hclk);
    arc   <= 3'h7;
    fault <= 1'b1;
    init3 <= 1'b1;
    wt(6, 1'b1, 110, n);
    `CHK(n >= 7 * T && n <= 9 * T + 10, 1'b1);
    $display("test early and low stage done");
  endtask

  task automatic t_single();
    int n;
    start(32'h6f, 16'h0300);
    @(posedge hclk);
    nmag <= 16'h0300;
    pa   <= 1'b1;
    repeat (8) @(negedge hclk);
    `CHK(retrip, 3'h0);
    @(posedge hclk);
    nmag <= 16'h0;
    pa   <= 1'b0;
    repeat (4) @(posedge hclk);
    arc   <= 3'h2;
    fault <= 1'b1;
    pb    <= 1'b1;
    wt(1, 1'b1, 10, n);
    `CHK(retrip, 3'h2);
    wt(7, 1'b1, 80, n);
    `CHK(inwin(n, 6), 1'b1);
    wt(12, 1'b1, 3, n);
    `CHK(pled, 3'h2);
    `CHK(mf, 3'h2);
    `CHK(zone, 1'b1);
    // pole B slow path must stop once its own aux contact opens
    repeat (80) @(negedge hclk);
    `CHK(sf, 3'h0);
    $display("test single pole done");
  endtask

  task automatic t_block();
    int n;
    start(32'h6d, 16'h0300);
    @(posedge hclk);
    arc   <= 3'h7;
    fault <= 1'b1;
    init3 <= 1'b1;
    wt(6, 1'b1, 80, n);
    @(posedge hclk);
    blk <= 1'b1;
    repeat (5) @(negedge hclk);
    `CHK(obs, 19'h0);
    @(posedge hclk);
    blk <= 1'b0;
    wt(6, 1'b1, 80, n);
    `CHK(inwin(n, 6), 1'b1);
    wr(`BF_A_CTRL, 32'h6c);
    repeat (3) @(negedge hclk);
    `CHK(obs, 19'h0);
    $display("test block done");
  endtask

  initial
  begin
    {ce, hsel, hwrite, htrans, haddr, hwdata, single, fault, lvl} = '0;
    {init3, blk, oos, pa, pb, pc, mech, arc, nmag} = '0;
    {mismatches, n_checks, cyc} = '0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ce      <= 1'b1;
    t_regs();
    t_main();
    t_gate();
    t_slow();
    t_early();
    t_single();
    t_block();
    tally_and_finish();
  end
endmodule
`default_nettype wire
